/* File: hdl/ivc_pkg.sv */
/*
  Constants for the interrupt vector and global control block: register
  offsets, field positions, reset values and vector table geometry.
  Assumes a single 100 MHz clock domain and 24-bit program addresses.
*/
package ivc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PC_W = 24;
  localparam int unsigned NUM_EXT = 5;
  localparam int unsigned VEC_NUM_W = 7;
  localparam int unsigned BOOT_LIM_W = 13;

  // register offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_MASK = 4'h2;

  // control register fields
  localparam int unsigned BIT_GLOBAL_EN = 15;
  localparam int unsigned BIT_BLOCK = 14;
  localparam int unsigned BIT_ALT = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h811f;
  localparam logic [15:0] CTRL_RESET = 16'h8000;

  // program address map
  localparam logic [23:0] RESET_VEC_ADDR = 24'h000000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] FIXED_VEC_LIMIT = 24'h000200;
  localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
  localparam logic [23:0] PRI_TABLE_END = 24'h0000ff;
  localparam logic [23:0] ALT_TABLE_BASE = 24'h000104;
  localparam logic [23:0] ALT_TABLE_END = 24'h0001ff;
  localparam logic [23:0] BOOT_PAGE_SIZE = 24'h000400;
  localparam logic [23:0] BOOT_ALT_OFFSET = 24'h0001fc;
  localparam logic [6:0] NUM_VECTORS = 7'h7e;
  localparam logic [6:0] NUM_TRAPS = 7'h08;
endpackage

/* File: hdl/irq_vector_ctrl.sv */
/*
  Interrupt vector placement and global interrupt control.
  Assumes the core presents vector requests and timed-block starts on the
  same clock, the configuration inputs are static after reset, and the
  external interrupt pins are asynchronous.
*/
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

// Contract
// - start at 000000h; fixed vectors below 000200h
// - primary table 00004h..0000FFh by default
// - alternate table 000104h..0001FFh without boot
// - with boot: base = limit*1024 - 508
// - alternate only when configuration permits it
// - each source owns its own vector
// - bit 8 selects table, resets 0
// - bit 15 global enable, traps always serviced
// - bit 14 reads timed block active
// - bits 4..0 edge polarity, 1 falling
module irq_vector_ctrl import ivc_pkg::*; #(
  parameter int unsigned BLOCK_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata_q,
  // configuration
  input wire logic alt_vector_config_gate,
  input wire logic boot_segment_present,
  input wire logic [BOOT_LIM_W-1:0] boot_segment_limit,
  // core side
  input wire logic vec_req,
  input wire logic [VEC_NUM_W-1:0] vec_num,
  output logic vec_valid_q,
  output logic vec_refused_q,
  output logic [PC_W-1:0] vec_addr_q,
  output logic [PC_W-1:0] start_pc_q,
  input wire logic block_start,
  input wire logic [BLOCK_W-1:0] block_len,
  output logic global_irq_enable_q,
  output logic timed_irq_block_active_q,
  // external interrupt pins and interrupt out
  input wire logic [NUM_EXT-1:0] ext_irq_pin,
  output logic irq_q
);
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [NUM_EXT-1:0] status_q, status_d, mask_q, mask_d;
  logic [NUM_EXT-1:0] sync1_q, sync2_q, prev_q, edge_ev;
  logic [BLOCK_W-1:0] block_cnt_q, block_cnt_d;
  logic [DATA_W-1:0] rdata_d;
  logic irq_d, vvalid_d, vref_d;
  logic [PC_W-1:0] vaddr_d, alt_base, base;
  logic use_alt;

  // external pins: two-flop synchroniser, edge picked per polarity bit
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_edge
      assign edge_ev[g] = ctrl_q[g] ? (prev_q[g] & ~sync2_q[g])
                                    : (~prev_q[g] & sync2_q[g]);
    end
  endgenerate

  // table base selection
  always_comb begin
    use_alt = ctrl_q[BIT_ALT] & alt_vector_config_gate;
    if (boot_segment_present) begin
      alt_base = PC_W'({11'h000, boot_segment_limit} * BOOT_PAGE_SIZE) - BOOT_ALT_OFFSET;
    end else begin
      alt_base = ALT_TABLE_BASE;
    end
    base = use_alt ? alt_base : PRI_TABLE_BASE;
  end

  // register file and status
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    status_d = status_q;
    if (reg_we && reg_addr == OFF_CTRL) begin
      ctrl_d = reg_wdata & CTRL_WMASK;
    end
    if (reg_we && reg_addr == OFF_MASK) begin
      mask_d = reg_wdata[NUM_EXT-1:0];
    end
    if (reg_we && reg_addr == OFF_STATUS) begin
      status_d = status_q & ~reg_wdata[NUM_EXT-1:0];
    end
    // a new edge wins over a same-cycle clear
    status_d = status_d | edge_ev;
    ctrl_d[BIT_BLOCK] = 1'b0;
    rdata_d = '0;
    if (reg_re) begin
      case (reg_addr)
        OFF_CTRL: begin
          rdata_d = ctrl_q;
          rdata_d[BIT_BLOCK] = timed_irq_block_active_q;
        end
        OFF_STATUS: rdata_d = {11'h000, status_q};
        OFF_MASK: rdata_d = {11'h000, mask_q};
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(status_d & mask_d);
  end

  // timed interrupt block counter, one step per clock
  always_comb begin
    if (block_start) begin
      block_cnt_d = block_len;
    end else if (block_cnt_q != '0) begin
      block_cnt_d = block_cnt_q - BLOCK_W'(1);
    end else begin
      block_cnt_d = '0;
    end
  end

  // vector fetch: traps always, interrupts only while globally enabled
  always_comb begin
    vvalid_d = 1'b0;
    vref_d = 1'b0;
    vaddr_d = vec_addr_q;
    if (vec_req) begin
      if (vec_num >= NUM_VECTORS ||
          (vec_num >= NUM_TRAPS && !ctrl_q[BIT_GLOBAL_EN])) begin
        vref_d = 1'b1;
      end else begin
        vvalid_d = 1'b1;
        vaddr_d = base + {16'h0000, vec_num, 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
      status_q <= '0;
      mask_q <= '0;
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
      block_cnt_q <= '0;
      reg_rdata_q <= '0;
      irq_q <= 1'b0;
      vec_valid_q <= 1'b0;
      vec_refused_q <= 1'b0;
      vec_addr_q <= RESET_TARGET_ADDR;
      start_pc_q <= RESET_VEC_ADDR;
      global_irq_enable_q <= 1'b1;
      timed_irq_block_active_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      mask_q <= mask_d;
      sync1_q <= ext_irq_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      block_cnt_q <= block_cnt_d;
      reg_rdata_q <= rdata_d;
      irq_q <= irq_d;
      vec_valid_q <= vvalid_d;
      vec_refused_q <= vref_d;
      vec_addr_q <= vaddr_d;
      start_pc_q <= RESET_VEC_ADDR;
      global_irq_enable_q <= ctrl_d[BIT_GLOBAL_EN];
      timed_irq_block_active_q <= block_cnt_d != '0;
    end
  end

  a_start_pc_fixed: assert property (@(posedge clk) start_pc_q == RESET_VEC_ADDR)
    else $error("start pc not at reset vector");
  a_primary_range: assert property (@(posedge clk) disable iff (srst)
    vec_req && !use_alt && $past(1'b1) |=> !vec_valid_q ||
      (vec_addr_q >= PRI_TABLE_BASE && vec_addr_q <= PRI_TABLE_END))
    else $error("primary vector out of table");
  a_alt_range: assert property (@(posedge clk) disable iff (srst)
    vec_req && use_alt && !boot_segment_present |=> !vec_valid_q ||
      (vec_addr_q >= ALT_TABLE_BASE && vec_addr_q <= ALT_TABLE_END))
    else $error("alternate vector out of table");
  a_boot_base: assert property (@(posedge clk) disable iff (srst)
    vec_req && use_alt && boot_segment_present && vec_num == '0 |=>
      vec_addr_q == PC_W'({11'h000, $past(boot_segment_limit)} * BOOT_PAGE_SIZE) - BOOT_ALT_OFFSET)
    else $error("boot alternate base wrong");
  a_alt_gated: assert property (@(posedge clk) disable iff (srst)
    !alt_vector_config_gate |-> base == PRI_TABLE_BASE)
    else $error("alternate table used without config");
  a_vector_unique: assert property (@(posedge clk) disable iff (srst)
    vec_req && ctrl_q[BIT_GLOBAL_EN] && vec_num < NUM_VECTORS |=>
      vec_valid_q && vec_addr_q == $past(base) + {16'h0000, $past(vec_num), 1'b0})
    else $error("vector address not per source");
  a_global_blocks: assert property (@(posedge clk) disable iff (srst)
    vec_req && !ctrl_q[BIT_GLOBAL_EN] && vec_num >= NUM_TRAPS |=> vec_refused_q && !vec_valid_q)
    else $error("interrupt serviced while disabled");
  a_block_status: assert property (@(posedge clk) disable iff (srst)
    block_start && block_len != '0 |=> timed_irq_block_active_q)
    else $error("block status not set");
  a_falling_edge: assert property (@(posedge clk) disable iff (srst)
    ctrl_q[0] && prev_q[0] && !sync2_q[0] |=> status_q[0])
    else $error("falling edge not captured");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (srst)
    reg_re && reg_addr == OFF_CTRL |=> (reg_rdata_q & 16'h3ee0) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  // register file, status, timed block and vector port consistency
  a_rising_edge: assert property (@(posedge clk) disable iff (srst)
    !ctrl_q[0] && !prev_q[0] && sync2_q[0] |=> status_q[0])
    else $error("rising edge not captured");

  a_wrong_edge: assert property (@(posedge clk) disable iff (srst)
    ctrl_q[1] && !prev_q[1] && sync2_q[1] && !status_q[1] |=> !status_q[1])
    else $error("edge of wrong polarity captured");

  a_status_sticky: assert property (@(posedge clk) disable iff (srst)
    status_q[0] && !(reg_we && reg_addr == OFF_STATUS && reg_wdata[0]) |=> status_q[0])
    else $error("status bit lost without clear");

  a_status_clear: assert property (@(posedge clk) disable iff (srst)
    reg_we && reg_addr == OFF_STATUS && reg_wdata[0] && !edge_ev[0] |=> !status_q[0])
    else $error("status bit not cleared");

  a_edge_sets: assert property (@(posedge clk) disable iff (srst)
    edge_ev[0] |=> status_q[0])
    else $error("edge lost against clear");

  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    irq_q == |(status_q & mask_q))
    else $error("interrupt level wrong");

  a_enable_copy: assert property (@(posedge clk) disable iff (srst)
    global_irq_enable_q == ctrl_q[BIT_GLOBAL_EN])
    else $error("global enable output wrong");

  a_block_flag: assert property (@(posedge clk) disable iff (srst)
    timed_irq_block_active_q == (block_cnt_q != '0))
    else $error("block flag and counter disagree");

  a_block_idle: assert property (@(posedge clk) disable iff (srst)
    !block_start && block_cnt_q == '0 |=> !timed_irq_block_active_q)
    else $error("block flag set while idle");

  a_ctrl_unused: assert property (@(posedge clk) disable iff (srst)
    (ctrl_q & ~CTRL_WMASK) == 16'h0000)
    else $error("unimplemented control bit stored");

  a_write_ctrl: assert property (@(posedge clk) disable iff (srst)
    reg_we && reg_addr == OFF_CTRL |=> ctrl_q == ($past(reg_wdata) & CTRL_WMASK))
    else $error("control write not taken");

  a_read_select: assert property (@(posedge clk) disable iff (srst)
    reg_re && reg_addr == OFF_CTRL |=> reg_rdata_q[BIT_ALT] == $past(ctrl_q[BIT_ALT]))
    else $error("table select read wrong");

  a_read_block: assert property (@(posedge clk) disable iff (srst)
    reg_re && reg_addr == OFF_CTRL |=> reg_rdata_q[BIT_BLOCK] == $past(timed_irq_block_active_q))
    else $error("block status read wrong");

  a_read_idle: assert property (@(posedge clk) disable iff (srst)
    !reg_re |=> reg_rdata_q == '0)
    else $error("read data without strobe");

  a_read_unmapped: assert property (@(posedge clk) disable iff (srst)
    reg_re && reg_addr > OFF_MASK |=> reg_rdata_q == '0)
    else $error("unmapped read nonzero");

  a_vec_quiet: assert property (@(posedge clk) disable iff (srst)
    !vec_req |=> !vec_valid_q && !vec_refused_q)
    else $error("vector answer without request");

  a_vec_exclusive: assert property (@(posedge clk) disable iff (srst)
    !(vec_valid_q && vec_refused_q))
    else $error("vector granted and refused");

  a_out_of_range: assert property (@(posedge clk) disable iff (srst)
    vec_req && vec_num >= NUM_VECTORS |=> vec_refused_q)
    else $error("unknown source not refused");

  a_trap_served: assert property (@(posedge clk) disable iff (srst)
    vec_req && vec_num < NUM_TRAPS |=> vec_valid_q)
    else $error("trap not serviced");

  a_addr_hold: assert property (@(posedge clk) disable iff (srst)
    !vec_req |=> $stable(vec_addr_q))
    else $error("vector address moved without grant");

  a_pri_default: assert property (@(posedge clk) disable iff (srst)
    !ctrl_q[BIT_ALT] |-> base == PRI_TABLE_BASE)
    else $error("alternate table used while deselected");

  a_alt_base: assert property (@(posedge clk) disable iff (srst)
    ctrl_q[BIT_ALT] && alt_vector_config_gate && !boot_segment_present |-> base == ALT_TABLE_BASE)
    else $error("alternate base wrong");

  a_fixed_region: assert property (@(posedge clk) disable iff (srst)
    vec_valid_q && !boot_segment_present |-> vec_addr_q < FIXED_VEC_LIMIT)
    else $error("vector outside fixed region");

  a_mask_write: assert property (@(posedge clk) disable iff (srst)
    reg_we && reg_addr == OFF_MASK |=> mask_q == $past(reg_wdata[NUM_EXT-1:0]))
    else $error("mask write not taken");

  a_sync_chain: assert property (@(posedge clk) disable iff (srst)
    sync2_q == $past(sync1_q))
    else $error("synchroniser chain broken");
endmodule

/* File: verification/core_model.sv */
/*
  Behavioural processor core: asks for vectors and starts timed blocks.
  Assumes the vector port answers one cycle after a request.
*/
`timescale 1ns/100ps
module core_model (
  // clock
  input wire logic clk,
  // vector port
  output logic vec_req,
  output logic [6:0] vec_num,
  input wire logic vec_valid_q,
  input wire logic vec_refused_q,
  input wire logic [23:0] vec_addr_q,
  // timed block
  output logic block_start,
  output logic [13:0] block_len
);
  initial begin
    vec_req = 1'b0;
    vec_num = 7'h00;
    block_start = 1'b0;
    block_len = 14'h0000;
  end
  // released qualifiers show the inverse so stale values never pass
  task automatic fetch(input logic [6:0] n, output logic [1:0] res, output logic [23:0] a);
    @(posedge clk);
    vec_req <= 1'b1;
    vec_num <= n;
    @(posedge clk);
    vec_req <= 1'b0;
    vec_num <= ~n;
    #1;
    res = {vec_valid_q, vec_refused_q};
    a = vec_addr_q;
  endtask
  task automatic blk(input logic [13:0] len);
    @(posedge clk);
    block_start <= 1'b1;
    block_len <= len;
    @(posedge clk);
    block_start <= 1'b0;
    block_len <= ~len;
  endtask
endmodule

/* File: verification/interrupt_vector_and_global_control_tb.sv */
/*
  Self-checking bench for the vector and global control block.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
module interrupt_vector_and_global_control_tb import ivc_pkg::*; ;
  logic clk = 1'b0, srst = 1'b1, we = 1'b0, re = 1'b0, gate = 1'b0, bootp = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wd = 16'h0000;
  logic [12:0] lim = 13'h0000;
  logic [4:0] pins = 5'h00;
  logic [15:0] rdata;
  logic vreq, vval, vref, bst, glb_en, blk, irq;
  logic [6:0] vnum;
  logic [23:0] vaddr, spc;
  logic [13:0] blen;
  int err_count = 0, checked = 0;
  always #5 clk = ~clk;
  irq_vector_ctrl DUT (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
    .reg_rdata_q(rdata), .alt_vector_config_gate(gate), .boot_segment_present(bootp), .boot_segment_limit(lim),
    .vec_req(vreq), .vec_num(vnum), .vec_valid_q(vval), .vec_refused_q(vref), .vec_addr_q(vaddr),
    .start_pc_q(spc), .block_start(bst), .block_len(blen), .global_irq_enable_q(glb_en),
    .timed_irq_block_active_q(blk), .ext_irq_pin(pins), .irq_q(irq));
  core_model core (.clk(clk), .vec_req(vreq), .vec_num(vnum), .vec_valid_q(vval), .vec_refused_q(vref),
    .vec_addr_q(vaddr), .block_start(bst), .block_len(blen));
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic vec(input logic [6:0] n, input logic [1:0] er, input logic [23:0] ea);
    logic [1:0] r;
    logic [23:0] a;
    core.fetch(n, r, a);
    chk({22'h0, r}, {22'h0, er});
    if (er == 2'b10) chk(a, ea);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFF_CTRL, 16'h8000);
    chk(spc, RESET_VEC_ADDR);
    chk(glb_en, 1'b1);
    wr(OFF_CTRL, 16'hffff);
    rd(OFF_CTRL, 16'h811f);
    rd(4'h3, 16'h0000);
    vec(7'h03, 2'b10, 24'h00000a);
    @(posedge clk) gate <= 1'b1;
    vec(7'h03, 2'b10, 24'h00010a);
    vec(7'h7d, 2'b10, 24'h0001fe);
    @(posedge clk) bootp <= 1'b1;
    lim <= 13'h0002;
    vec(7'h03, 2'b10, (24'd2 * 24'd1024) - 24'd508 + 24'd6);
    vec(7'h00, 2'b10, (24'd2 * 24'd1024) - 24'd508);
    vec(7'h7e, 2'b01, 24'h0);
    wr(OFF_CTRL, 16'h0000);
    #1 chk(glb_en, 1'b0);
    vec(7'h09, 2'b01, 24'h0);
    vec(7'h02, 2'b10, 24'h000008);
    core.blk(14'd20);
    #1 chk(blk, 1'b1);
    rd(OFF_CTRL, 16'h4000);
    repeat (25) @(posedge clk);
    rd(OFF_CTRL, 16'h0000);
    // pin0 rising counts, pin1 rising must not under falling polarity
    wr(OFF_MASK, 16'h001f);
    wr(OFF_CTRL, 16'h8002);
    @(posedge clk) pins <= 5'h03;
    repeat (8) @(posedge clk);
    #1 chk(irq, 1'b1);
    rd(OFF_STATUS, 16'h0001);
    wr(OFF_STATUS, 16'h0001);
    @(posedge clk) pins <= 5'h00;
    repeat (8) @(posedge clk);
    rd(OFF_STATUS, 16'h0002);
    wr(OFF_MASK, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rd(OFF_CTRL, 16'h8000);
    chk(glb_en, 1'b1);
    rd(OFF_STATUS, 16'h0000);
    report_and_stop();
  end
endmodule
